// ---- logic/reset_seq_pkg.sv ----
// constants and types for the system reset sequencer
// Operation
// - The reset pin is a reset source only when the build-time pin option selects reset.
// - When enabled, the reset pin is active low and a low level resets the whole system.
// - Normal running happens only while the enabled reset pin stays high.
// - The pin reset acts both during power-up and during normal execution.
// - The sequence first waits, held in reset, until the pin is released high.
// - After release, every system register is loaded with its initial value.
// - Then an oscillator warm-up period passes before the system clock is delivered.
// - At the end of the sequence, fetch starts at program address zero.
// - A low-voltage detector trip asserts a system reset.
// - A watchdog overflow, after the program stopped clearing it, asserts a system reset.
// - After a watchdog reset completes the sequence, the device returns to normal mode.
// - While reset is active, execution halts and the PC is cleared; registers are forced until warm-up starts.
package reset_seq_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int INIT_CYCLES = 16;
  localparam int WARMUP_OSC_CLOCKS = 4096;
  localparam int WARMUP_CYCLES = WARMUP_OSC_CLOCKS;
  localparam int CNT_W = 13;
  localparam logic [11:0] RESET_VECTOR = 12'h000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT_PIN,
    ST_INIT,
    ST_WARMUP,
    ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic pin_reset;
    logic low_voltage;
    logic watchdog;
  } cause_t;

endpackage

// ---- logic/system_reset_sequencer.sv ----
// reset sequencer combining pin, low-voltage and watchdog resets
`timescale 1ns/100ps
module system_reset_sequencer #(
  parameter int WARMUP_LEN = reset_seq_pkg::WARMUP_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PIN_RESET_ENABLE,
  input wire logic EXT_RESET_N,
  input wire logic LOW_VOLTAGE_DETECTOR_TRIP,
  input wire logic WATCHDOG_OVERFLOW,
  output logic SYS_RESET,
  output logic REG_INIT,
  output logic CPU_CLK_ENABLE,
  output logic CPU_RUN,
  output logic [11:0] FETCH_ADDR,
  output reset_seq_pkg::cause_t LAST_CAUSE
);
  import reset_seq_pkg::*;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= EXT_RESET_N;
      pin_sync_q <= pin_meta_q;
    end
  end

  // pin low while enabled holds reset; disabled pin is ignored
  logic pin_hold;
  // a low pin asserts at once; release waits for both synchroniser stages to see high
  assign pin_hold = PIN_RESET_ENABLE & (~EXT_RESET_N | ~pin_sync_q);

  // a trip restarts the sequence from any state
  logic restart;
  assign restart = pin_hold | LOW_VOLTAGE_DETECTOR_TRIP | WATCHDOG_OVERFLOW;

  // ---------------------------------------------------------------
  // sequence state machine
  // ---------------------------------------------------------------
  seq_state_t state_q;
  seq_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic cnt_done;

  always_comb begin
    cnt_done = 1'b0;
    case (state_q)
      ST_INIT: cnt_done = (cnt_q == CNT_W'(INIT_CYCLES - 1));
      ST_WARMUP: cnt_done = (cnt_q == CNT_W'(WARMUP_LEN - 1));
      default: cnt_done = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    if (restart) begin
      state_d = ST_WAIT_PIN;
    end else begin
      case (state_q)
        ST_WAIT_PIN: state_d = ST_INIT;
        ST_INIT: if (cnt_done) state_d = ST_WARMUP;
        ST_WARMUP: if (cnt_done) state_d = ST_RUN;
        ST_RUN: state_d = ST_RUN;
        default: state_d = ST_WAIT_PIN;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_WAIT_PIN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || state_d != state_q) begin
      cnt_q <= '0;
    end else if (state_q == ST_INIT || state_q == ST_WARMUP) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SYS_RESET <= 1'b1;
      REG_INIT <= 1'b1;
      CPU_CLK_ENABLE <= 1'b0;
      CPU_RUN <= 1'b0;
      FETCH_ADDR <= RESET_VECTOR;
    end else begin
      SYS_RESET <= (state_d != ST_RUN);
      REG_INIT <= (state_d == ST_INIT) | (state_d == ST_WAIT_PIN);
      CPU_CLK_ENABLE <= (state_d == ST_RUN);
      CPU_RUN <= (state_d == ST_RUN);
      if (state_d != ST_RUN) begin
        FETCH_ADDR <= RESET_VECTOR;
      end
    end
  end

  // cause of the latest reset, kept until the next one
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LAST_CAUSE <= '0;
    end else if (restart) begin
      LAST_CAUSE <= '{pin_reset: pin_hold, low_voltage: LOW_VOLTAGE_DETECTOR_TRIP,
                      watchdog: WATCHDOG_OVERFLOW};
    end
  end

endmodule

// ---- verification/reset_seq_asserts.sv ----
// port checks for the reset sequencer
`timescale 1ns/100ps
module reset_seq_asserts (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PIN_RESET_ENABLE,
  input wire logic EXT_RESET_N,
  input wire logic LOW_VOLTAGE_DETECTOR_TRIP,
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic SYS_RESET,
  input wire logic REG_INIT,
  input wire logic CPU_CLK_ENABLE,
  input wire logic CPU_RUN,
  input wire logic [11:0] FETCH_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  lvd_reset_a: assert property (LOW_VOLTAGE_DETECTOR_TRIP |=> SYS_RESET && !CPU_RUN)
    else $error("low voltage trip missed");
  wdog_reset_a: assert property (WATCHDOG_OVERFLOW |=> SYS_RESET && !CPU_RUN)
    else $error("watchdog reset missed");
  pin_reset_a: assert property (PIN_RESET_ENABLE && !EXT_RESET_N |=> SYS_RESET)
    else $error("pin reset missed");
  pin_off_a: assert property (CPU_RUN && !PIN_RESET_ENABLE &&
    !LOW_VOLTAGE_DETECTOR_TRIP && !WATCHDOG_OVERFLOW |=> CPU_RUN)
    else $error("disabled pin reset");
  pin_high_a: assert property (CPU_RUN && PIN_RESET_ENABLE |-> $past(EXT_RESET_N, 3))
    else $error("ran with pin low");
  halt_clear_a: assert property (SYS_RESET |-> !CPU_RUN && FETCH_ADDR == 12'h000)
    else $error("ran during reset");
  init_hold_a: assert property ($rose(REG_INIT) |-> REG_INIT [*8])
    else $error("init too short");
  warm_up_a: assert property ($rose(CPU_RUN) |-> CPU_CLK_ENABLE && !$past(REG_INIT))
    else $error("no warm up before run");
endmodule
bind system_reset_sequencer reset_seq_asserts chk (.CLK, .RESET, .PIN_RESET_ENABLE,
  .EXT_RESET_N, .LOW_VOLTAGE_DETECTOR_TRIP, .WATCHDOG_OVERFLOW, .SYS_RESET, .REG_INIT,
  .CPU_CLK_ENABLE, .CPU_RUN, .FETCH_ADDR);

// ---- verification/reset_pin_model.sv ----
// external reset network driving the reset pin
`timescale 1ns/100ps
module reset_pin_model (
  input wire logic clk,
  input wire logic pulse,
  output logic rst_n
);
  int cnt = 40;
  always @(posedge clk) begin
    if (pulse) cnt <= 2;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign rst_n = (cnt == 0);
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb;
  import reset_seq_pkg::*;
  logic CLK = 0, RESET = 1, en = 1, low_voltage_detector = 0, wd = 0, pulse = 0, rst_n;
  logic SYS_RESET, REG_INIT, CPU_CLK_ENABLE, CPU_RUN;
  logic [11:0] FETCH_ADDR;
  cause_t LAST_CAUSE;
  int n_errors = 0, checks_done = 0;
  // enable, pin, low voltage, watchdog, reset seen, cause
  logic [7:0] rows [4] = '{8'hcc, 8'haa, 8'h99, 8'h41};
  always #2.5 CLK = ~CLK;
  reset_pin_model pm (.clk(CLK), .pulse, .rst_n);
  system_reset_sequencer #(.WARMUP_LEN(8)) uut (.CLK, .RESET, .PIN_RESET_ENABLE(en),
    .EXT_RESET_N(rst_n), .LOW_VOLTAGE_DETECTOR_TRIP(low_voltage_detector), .WATCHDOG_OVERFLOW(wd),
    .SYS_RESET, .REG_INIT, .CPU_CLK_ENABLE, .CPU_RUN, .FETCH_ADDR, .LAST_CAUSE);
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_run;
    for (int i = 0; i < 60 && CPU_RUN !== 1'b1; i++) @(posedge CLK) #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000 n_errors++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge CLK);
    #1 RESET = 0;
    repeat (20) @(posedge CLK);
    #1 check(CPU_RUN, 0);
    wait_run;
    check({CPU_RUN, FETCH_ADDR}, 13'h1000);
    foreach (rows[i]) begin
      {en, pulse, low_voltage_detector, wd} = rows[i][7:4];
      @(posedge CLK) #1 {pulse, low_voltage_detector, wd} = 0;
      repeat (4) @(posedge CLK);
      #1 check(SYS_RESET, rows[i][3]);
      check({REG_INIT, CPU_CLK_ENABLE}, {rows[i][3], !rows[i][3]});
      wait_run;
      check({CPU_RUN, LAST_CAUSE}, {1'b1, rows[i][2:0]});
      repeat (4) @(posedge CLK);
      #1 en = 1;
      $display("row %0d done", i);
    end
    low_voltage_detector = 1;
    repeat (50) @(posedge CLK);
    #1 check({SYS_RESET, CPU_RUN}, 2'b10);
    low_voltage_detector = 0;
    wait_run;
    check(CPU_RUN, 1);
    $display("held trip done");
    @(posedge CLK) #1 RESET = 1;
    repeat (3) @(posedge CLK);
    #1 check({SYS_RESET, REG_INIT, CPU_RUN}, 3'b110);
    RESET = 0;
    wait_run;
    check({CPU_RUN, FETCH_ADDR}, 13'h1000);
    $display("mid-run reset done");
    finish_test;
  end
endmodule
